/* common/rgs_pkg.sv */
// Package with register map, field positions and timing for the receive gain control block.
package rgs_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam real SQ_WINDOW_US = 50.0;
   localparam real SQ_START_US = 18.88;
   // Least time rounds up, window length rounds down; both at least one cycle.
   localparam int unsigned SQ_WINDOW_CYC = int'($floor(SQ_WINDOW_US * CLK_HZ / 1.0e6));
   localparam int unsigned SQ_START_CYC = int'($ceil(SQ_START_US * CLK_HZ / 1.0e6));
   localparam int unsigned SQ_MAX_TRANS = 2;
   localparam int unsigned AGC_PULSES = 8;
   localparam logic [3:0] GAIN_MAX = 4'hA;
   localparam logic [3:0] GAIN_PRESET = 4'h4;
   localparam logic [3:0] GAIN_ZERO = 4'h0;
   localparam logic [3:0] WIN_MAX = 4'h4;
   localparam logic [3:0] RSSI_MAX = 4'hD;
   localparam logic [3:0] NFC_GAIN_CODE = 4'h6;
   // Register byte addresses.
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_GAIN = 8'h08;
   localparam logic [7:0] ADDR_RSSI = 8'h0C;
   localparam logic [7:0] ADDR_CTRL = 8'h10;
   // Configuration register fields.
   localparam int unsigned CFG_MANUAL_LSB = 0;
   localparam int unsigned CFG_AGC_EN = 4;
   localparam int unsigned CFG_AGC_MODE = 5;
   localparam int unsigned CFG_AGC_ALG = 6;
   localparam int unsigned CFG_SQ_DYN = 7;
   localparam int unsigned CFG_CLIP = 8;
   localparam int unsigned CFG_GAIN_FORCE = 9;
   localparam logic [31:0] CFG_RESET = 32'h0000_0010;
   // Command register bits, write one to issue.
   localparam int unsigned CMD_RESET_GAIN = 0;
   localparam int unsigned CMD_SQUELCH = 1;
   localparam int unsigned CMD_CLEAR_RSSI = 2;
endpackage : rgs_pkg

/* design/rgs_gain_ctrl.sv */
// Gain state, squelch, AGC and RSSI controller with an APB register slave.
`timescale 1ns/1ps
module rgs_gain_ctrl #(
   parameter int unsigned SQ_WINDOW_CYC = rgs_pkg::SQ_WINDOW_CYC,
   parameter int unsigned SQ_START_CYC = rgs_pkg::SQ_START_CYC
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxActive,
   input wire logic txEnd,
   input wire logic maskRxExpired,
   input wire logic digOut,
   input wire logic agcCmpOut,
   input wire logic subPulse,
   input wire logic [3:0] rssiLevelA,
   input wire logic [3:0] rssiLevelB,
   output logic [2:0] digWindow,
   output logic [2:0] stage23Reduction,
   output logic clipEnable
);
   logic [31:0] cfg_q;
   logic [3:0] gain_q;
   logic [3:0] gainStat_q;
   logic [3:0] rssiA_q;
   logic [3:0] rssiB_q;
   logic rxPrev_q;
   logic digPrev_q;
   logic agcPrev_q;
   logic agcRun_q;
   logic [3:0] pulseCnt_q;
   logic sqActive_q;
   logic sqDyn_q;
   logic sqWait_q;
   logic [1:0] sqTrans_q;
   logic [$clog2(SQ_WINDOW_CYC + 1)-1:0] sqCnt_q;
   logic [$clog2(SQ_START_CYC + 1)-1:0] sqStartCnt_q;

   logic wrEn;
   logic rdEn;
   logic cmdGainReset;
   logic cmdSquelch;
   logic cmdClearRssi;
   logic rxRise;
   logic rxFall;
   logic [3:0] manualGain;
   logic sqStep;
   logic agcStep;
   logic agcWindow;
   logic sqWinEnd;
   logic [3:0] rssiASat;
   logic [3:0] rssiBSat;

   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && (paddr > rgs_pkg::ADDR_CTRL || paddr[1:0] != 2'b00);
   assign manualGain = (cfg_q[rgs_pkg::CFG_MANUAL_LSB +: 4] > rgs_pkg::GAIN_MAX) ?
      rgs_pkg::GAIN_MAX : cfg_q[rgs_pkg::CFG_MANUAL_LSB +: 4];
   assign cmdGainReset = wrEn && paddr == rgs_pkg::ADDR_CMD && pwdata[rgs_pkg::CMD_RESET_GAIN];
   // A squelch request while a reception runs is dropped without a trace.
   assign cmdSquelch = wrEn && paddr == rgs_pkg::ADDR_CMD && pwdata[rgs_pkg::CMD_SQUELCH]
      && !rxActive;
   assign cmdClearRssi = wrEn && paddr == rgs_pkg::ADDR_CMD && pwdata[rgs_pkg::CMD_CLEAR_RSSI];
   assign rxRise = rxActive && !rxPrev_q;
   assign rxFall = !rxActive && rxPrev_q;

   // Configuration register; reset value enables AGC, whole reception, preset start.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cfg_q <= rgs_pkg::CFG_RESET;
      end else if (wrEn && paddr == rgs_pkg::ADDR_CFG) begin
         cfg_q <= {22'h00_0000, pwdata[9:0]};
      end
   end

   always_comb begin
      prdata = 32'h0000_0000;
      if (rdEn) begin
         unique case (paddr)
            rgs_pkg::ADDR_CFG: prdata = cfg_q;
            rgs_pkg::ADDR_GAIN: prdata = {28'h000_0000, gainStat_q};
            rgs_pkg::ADDR_RSSI: prdata = {24'h00_0000, rssiB_q, rssiA_q};
            rgs_pkg::ADDR_CTRL: prdata = {28'h000_0000, gain_q};
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rxPrev_q <= 1'b0;
         digPrev_q <= 1'b0;
         agcPrev_q <= 1'b0;
      end else begin
         rxPrev_q <= rxActive;
         digPrev_q <= digOut;
         agcPrev_q <= agcCmpOut;
      end
   end

   // Dynamic squelch start delay after transmit end.
   always_ff @(posedge clk_sys) begin
      if (srst || cmdGainReset) begin
         sqWait_q <= 1'b0;
         sqStartCnt_q <= '0;
      end else if (txEnd && cfg_q[rgs_pkg::CFG_SQ_DYN]) begin
         sqWait_q <= 1'b1;
         sqStartCnt_q <= '0;
      end else if (sqWait_q && (maskRxExpired || sqStartCnt_q ==
            ($bits(sqStartCnt_q))'(SQ_START_CYC - 1))) begin
         sqWait_q <= 1'b0;
      end else if (sqWait_q) begin
         sqStartCnt_q <= sqStartCnt_q + 1'b1;
      end
   end

   assign sqWinEnd = sqActive_q && sqCnt_q == ($bits(sqCnt_q))'(SQ_WINDOW_CYC - 1);
   assign sqStep = sqWinEnd && (sqTrans_q == 2'd3) && gain_q < rgs_pkg::GAIN_MAX;

   // Squelch observation: windows of fixed length, transitions counted up to three.
   always_ff @(posedge clk_sys) begin
      if (srst || cmdGainReset) begin
         sqActive_q <= 1'b0;
         sqDyn_q <= 1'b0;
         sqCnt_q <= '0;
         sqTrans_q <= 2'd0;
      end else if (sqActive_q && sqDyn_q && maskRxExpired) begin
         sqActive_q <= 1'b0;
      end else if (!sqActive_q && (cmdSquelch || (sqWait_q && !maskRxExpired &&
            sqStartCnt_q == ($bits(sqStartCnt_q))'(SQ_START_CYC - 1)))) begin
         sqActive_q <= 1'b1;
         sqDyn_q <= !cmdSquelch;
         sqCnt_q <= '0;
         sqTrans_q <= 2'd0;
      end else if (sqActive_q) begin
         if (sqWinEnd) begin
            sqCnt_q <= '0;
            sqTrans_q <= 2'd0;
            // A quiet window or the last state ends the procedure.
            if (!sqStep) begin
               sqActive_q <= 1'b0;
            end
         end else begin
            sqCnt_q <= sqCnt_q + 1'b1;
            if (digOut != digPrev_q && sqTrans_q != 2'd3) begin
               sqTrans_q <= sqTrans_q + 2'd1;
            end
         end
      end
   end

   // AGC window: whole reception, or the first eight sub-carrier pulses.
   always_ff @(posedge clk_sys) begin
      if (srst || cmdGainReset || !rxActive) begin
         agcRun_q <= 1'b0;
         pulseCnt_q <= 4'h0;
      end else begin
         if (rxRise) begin
            agcRun_q <= cfg_q[rgs_pkg::CFG_AGC_EN];
         end
         if (subPulse && pulseCnt_q != 4'(rgs_pkg::AGC_PULSES)) begin
            pulseCnt_q <= pulseCnt_q + 4'h1;
         end
      end
   end

   assign agcWindow = agcRun_q && cfg_q[rgs_pkg::CFG_AGC_EN] &&
      (!cfg_q[rgs_pkg::CFG_AGC_MODE] || pulseCnt_q != 4'(rgs_pkg::AGC_PULSES));
   assign agcStep = agcWindow && agcCmpOut != agcPrev_q && gain_q < rgs_pkg::GAIN_MAX;

   // Gain state; squelch reduction persists until the gain reset command, the end of a reception or an AGC start.
   always_ff @(posedge clk_sys) begin
      if (srst || cmdGainReset) begin
         gain_q <= manualGain;
      end else if (rxRise && cfg_q[rgs_pkg::CFG_AGC_EN]) begin
         gain_q <= cfg_q[rgs_pkg::CFG_AGC_ALG] ? rgs_pkg::GAIN_ZERO : rgs_pkg::GAIN_PRESET;
      end else if (rxFall) begin
         gain_q <= manualGain;
      end else if (sqStep || agcStep) begin
         gain_q <= gain_q + 4'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         gainStat_q <= rgs_pkg::GAIN_ZERO;
      end else if (cmdGainReset) begin
         gainStat_q <= manualGain;
      end else if (rxRise) begin
         gainStat_q <= gain_q;
      end
   end

   assign rssiASat = (rssiLevelA > rgs_pkg::RSSI_MAX) ? rgs_pkg::RSSI_MAX : rssiLevelA;
   assign rssiBSat = (rssiLevelB > rgs_pkg::RSSI_MAX) ? rgs_pkg::RSSI_MAX : rssiLevelB;

   // Peak hold per channel, live only while receive-active is high.
   always_ff @(posedge clk_sys) begin
      if (srst || cmdGainReset || cmdClearRssi || agcStep || rxRise) begin
         rssiA_q <= 4'h0;
         rssiB_q <= 4'h0;
      end else if (rxActive) begin
         if (rssiASat > rssiA_q) begin
            rssiA_q <= rssiASat;
         end
         if (rssiBSat > rssiB_q) begin
            rssiB_q <= rssiBSat;
         end
      end
   end

   // Five window settings, then six gain steps; the force bit overrides both.
   always_comb begin
      if (cfg_q[rgs_pkg::CFG_GAIN_FORCE]) begin
         digWindow = rgs_pkg::WIN_MAX[2:0];
         stage23Reduction = 3'd2;
      end else if (gain_q > rgs_pkg::WIN_MAX) begin
         digWindow = rgs_pkg::WIN_MAX[2:0];
         stage23Reduction = 3'(gain_q - rgs_pkg::WIN_MAX);
      end else begin
         digWindow = gain_q[2:0];
         stage23Reduction = 3'd0;
      end
   end

   assign clipEnable = cfg_q[rgs_pkg::CFG_CLIP];

   // Checks are listed without grouping by concern; each one names the rule it guards.
   a_gain_sat: assert property (@(posedge clk_sys) disable iff (srst)
      gain_q <= rgs_pkg::GAIN_MAX) else $error("Gain state above ten.");

   a_sq_reject: assert property (@(posedge clk_sys) disable iff (srst)
      (wrEn && paddr == rgs_pkg::ADDR_CMD && pwdata[rgs_pkg::CMD_SQUELCH] && rxActive
      && !sqActive_q && !sqWait_q) |=> !sqActive_q) else $error("Squelch taken in reception.");

   a_stat_latch: assert property (@(posedge clk_sys) disable iff (srst)
      (rxRise && !cmdGainReset) |=> gainStat_q == $past(gain_q)) else $error("Status not latched.");

   a_agc_start: assert property (@(posedge clk_sys) disable iff (srst)
      (rxRise && !cmdGainReset && cfg_q[rgs_pkg::CFG_AGC_EN] && !cfg_q[rgs_pkg::CFG_AGC_ALG])
      |=> gain_q == rgs_pkg::GAIN_PRESET) else $error("AGC preset start wrong.");

   a_rssi_max: assert property (@(posedge clk_sys) disable iff (srst)
      rssiA_q <= rgs_pkg::RSSI_MAX && rssiB_q <= rgs_pkg::RSSI_MAX) else $error("RSSI over 13.");

   a_rssi_frozen: assert property (@(posedge clk_sys) disable iff (srst)
      (!rxActive && !$past(rxActive) && !cmdClearRssi && !cmdGainReset) |=> $stable(rssiA_q))
      else $error("RSSI moved while idle.");

   a_rssi_agc: assert property (@(posedge clk_sys) disable iff (srst)
      agcStep |=> rssiA_q == 4'h0 && rssiB_q == 4'h0) else $error("RSSI kept over AGC step.");

   a_reset_load: assert property (@(posedge clk_sys) disable iff (srst)
      cmdGainReset |=> gain_q == $past(manualGain) && !sqActive_q) else $error("Reset lost.");

   a_sq_down: assert property (@(posedge clk_sys) disable iff (srst)
      (sqStep && !agcStep && !rxRise && !rxFall && !cmdGainReset) |=> gain_q == $past(gain_q) + 4'h1)
      else $error("Squelch step missed.");

   a_force_win: assert property (@(posedge clk_sys) disable iff (srst)
      cfg_q[rgs_pkg::CFG_GAIN_FORCE] |-> digWindow == 3'd4 && stage23Reduction == 3'd2)
      else $error("Force bit ignored.");

   a_agc_clear: assert property (@(posedge clk_sys) disable iff (srst)
      !rxActive |=> !agcRun_q)
      else $error("AGC kept running after reception.");

   a_agc_reload: assert property (@(posedge clk_sys) disable iff (srst)
      (rxFall && !cmdGainReset) |=> gain_q == $past(manualGain))
      else $error("Gain not reloaded at reception end.");

   a_agc_down: assert property (@(posedge clk_sys) disable iff (srst)
      (agcStep && !rxRise && !rxFall && !cmdGainReset) |=> gain_q == $past(gain_q) + 4'h1)
      else $error("AGC step missed.");

   a_agc_off: assert property (@(posedge clk_sys) disable iff (srst)
      !cfg_q[rgs_pkg::CFG_AGC_EN] |-> !agcStep)
      else $error("AGC stepped while disabled.");

   a_agc_pulses: assert property (@(posedge clk_sys) disable iff (srst)
      (cfg_q[rgs_pkg::CFG_AGC_MODE] && pulseCnt_q == 4'(rgs_pkg::AGC_PULSES)) |-> !agcStep)
      else $error("AGC stepped after its pulses.");

   a_agc_zero: assert property (@(posedge clk_sys) disable iff (srst)
      (rxRise && !cmdGainReset && cfg_q[rgs_pkg::CFG_AGC_EN] && cfg_q[rgs_pkg::CFG_AGC_ALG])
      |=> gain_q == rgs_pkg::GAIN_ZERO) else $error("AGC zero start wrong.");

   a_rssi_start: assert property (@(posedge clk_sys) disable iff (srst)
      rxRise |=> rssiA_q == 4'h0 && rssiB_q == 4'h0)
      else $error("RSSI not restarted at reception.");

   a_rssi_mono: assert property (@(posedge clk_sys) disable iff (srst)
      (rxActive && !rxRise && !agcStep && !cmdClearRssi && !cmdGainReset)
      |=> rssiA_q >= $past(rssiA_q) && rssiB_q >= $past(rssiB_q))
      else $error("RSSI peak hold fell.");

   a_rssi_clear: assert property (@(posedge clk_sys) disable iff (srst)
      cmdClearRssi |=> rssiA_q == 4'h0 && rssiB_q == 4'h0)
      else $error("RSSI not cleared on command.");

   a_sq_quiet: assert property (@(posedge clk_sys) disable iff (srst)
      (sqWinEnd && sqTrans_q != 2'd3) |=> !sqActive_q)
      else $error("Squelch ran past a quiet window.");

   a_sq_hold: assert property (@(posedge clk_sys) disable iff (srst)
      (sqWinEnd && gain_q == rgs_pkg::GAIN_MAX) |=> !sqActive_q && gain_q == rgs_pkg::GAIN_MAX)
      else $error("Squelch ran past the last state.");

   a_sq_window: assert property (@(posedge clk_sys) disable iff (srst)
      sqCnt_q < ($bits(sqCnt_q))'(SQ_WINDOW_CYC))
      else $error("Squelch window overran.");

   a_dyn_stop: assert property (@(posedge clk_sys) disable iff (srst)
      (sqActive_q && sqDyn_q && maskRxExpired) |=> !sqActive_q)
      else $error("Dynamic squelch outlived the mask.");

   a_sq_cmd: assert property (@(posedge clk_sys) disable iff (srst)
      (cmdSquelch && !cmdGainReset && !sqActive_q) |=> sqActive_q && !sqDyn_q)
      else $error("Squelch command not taken.");

   a_stat_reset: assert property (@(posedge clk_sys) disable iff (srst)
      cmdGainReset |=> gainStat_q == $past(manualGain))
      else $error("Status not loaded on reset command.");

   a_win_range: assert property (@(posedge clk_sys) disable iff (srst)
      digWindow <= 3'd4 && stage23Reduction <= 3'd6)
      else $error("Window or reduction out of range.");

   a_win_map: assert property (@(posedge clk_sys) disable iff (srst)
      (!cfg_q[rgs_pkg::CFG_GAIN_FORCE] && gain_q <= rgs_pkg::WIN_MAX)
      |-> digWindow == gain_q[2:0] && stage23Reduction == 3'd0)
      else $error("Window setting does not follow gain.");

   // Covers show that each loop really reaches its interesting state.
   c_sq_step: cover property (@(posedge clk_sys) sqStep);
   c_agc_pulses: cover property (@(posedge clk_sys) agcRun_q && pulseCnt_q == 4'h8);
   c_agc_step: cover property (@(posedge clk_sys) agcStep);
   c_dyn_sq: cover property (@(posedge clk_sys) sqActive_q && sqDyn_q);
   c_clear_rssi: cover property (@(posedge clk_sys) cmdClearRssi && rssiA_q != 4'h0);
endmodule : rgs_gain_ctrl

/* tb/rgs_rx_model.sv */
// Behavioural model of the receive framing logic that feeds the gain controller.
`timescale 1ns/1ps
module rgs_rx_model (
   input wire logic clk_sys,
   output logic rxActive,
   output logic txEnd,
   output logic maskRxExpired,
   output logic digOut,
   output logic agcCmpOut,
   output logic subPulse,
   output logic [3:0] rssiLevelA,
   output logic [3:0] rssiLevelB
);
   // The framing side starts idle: no reception, no pulses, quiet comparators.
   initial begin
      rxActive = 1'b0;
      txEnd = 1'b0;
      maskRxExpired = 1'b0;
      digOut = 1'b0;
      agcCmpOut = 1'b0;
      subPulse = 1'b0;
      rssiLevelA = 4'h0;
      rssiLevelB = 4'h0;
   end
   // Digitizer noise: one edge every per cycles.
   task automatic noise(input int cyc, input int per);
      for (int i = 1; i <= cyc; i++) begin
         @(posedge clk_sys);
         if (i % per == 0) begin
            digOut <= ~digOut;
         end
      end
   endtask : noise
   // Pulses are one cycle wide with one idle cycle after each, as the framing logic makes them.
   task automatic strobe(input int n, input int sel);
      repeat (n) begin
         @(posedge clk_sys);
         case (sel)
            0: txEnd <= 1'b1;
            1: maskRxExpired <= 1'b1;
            2: subPulse <= 1'b1;
            default: agcCmpOut <= ~agcCmpOut;
         endcase
         @(posedge clk_sys);
         {txEnd, maskRxExpired, subPulse} <= 3'h0;
      end
   endtask : strobe
   task automatic frame(input logic on);
      @(posedge clk_sys);
      rxActive <= on;
   endtask : frame
   task automatic level(input logic [3:0] a, input logic [3:0] b);
      @(posedge clk_sys);
      rssiLevelA <= a;
      rssiLevelB <= b;
   endtask : level
endmodule : rgs_rx_model

/* tb/tb_top.sv */
// Self-checking bench for the receive gain controller and its APB registers.
`timescale 1ns/1ps
module tb_top;
   // Short windows keep the run brief; the squelch expectations count in windows.
   localparam int unsigned WIN = 20;
   localparam int unsigned START = 5;
   typedef struct {logic [3:0] man; logic [3:0] gain; logic [2:0] win; logic [2:0] red;} rgs_row_t;
   logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, clipEnable, errv;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [2:0] digWindow, stage23Reduction;
   logic rxActive, txEnd, maskRxExpired, digOut, agcCmpOut, subPulse;
   logic [3:0] rssiLevelA, rssiLevelB;
   int numErrors = 0;
   int checks = 0;
   rgs_row_t rows [6] = '{'{4'h0, 4'h0, 3'h0, 3'h0}, '{4'h3, 4'h3, 3'h3, 3'h0},
      '{4'h4, 4'h4, 3'h4, 3'h0}, '{4'h7, 4'h7, 3'h4, 3'h3}, '{4'hA, 4'hA, 3'h4, 3'h6},
      '{4'hF, 4'hA, 3'h4, 3'h6}};
   rgs_gain_ctrl #(.SQ_WINDOW_CYC(WIN), .SQ_START_CYC(START)) u_rgs_gain_ctrl (.clk_sys, .srst,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxActive, .txEnd,
      .maskRxExpired, .digOut, .agcCmpOut, .subPulse, .rssiLevelA, .rssiLevelB, .digWindow,
      .stage23Reduction, .clipEnable);
   rgs_rx_model u_rgs_rx_model (.clk_sys, .rxActive, .txEnd, .maskRxExpired, .digOut, .agcCmpOut,
      .subPulse, .rssiLevelA, .rssiLevelB);
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) begin
         numErrors++;
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input string what, input logic [7:0] a, input logic [11:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, 32'(exp), rdv);
   endtask : rdchk
   task automatic cmd(input int b);
      apb(1'b1, rgs_pkg::ADDR_CMD, 32'h0000_0001 << b);
   endtask : cmd
   task automatic cfg(input logic [31:0] d);
      apb(1'b1, rgs_pkg::ADDR_CFG, d);
      cmd(rgs_pkg::CMD_RESET_GAIN);
   endtask : cfg
   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, numErrors);
      if (numErrors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20000) @(posedge clk_sys);
      numErrors++;
      report_and_stop();
   end
   initial begin
      srst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      rdchk("cfg", rgs_pkg::ADDR_CFG, 12'(rgs_pkg::CFG_RESET));
      rdchk("status", rgs_pkg::ADDR_GAIN, 12'h000);
      rdchk("rssi", rgs_pkg::ADDR_RSSI, 12'h000);
      rdchk("unmapped", 8'h14, 12'h000);
      chk("slverr", 32'h0000_0001, 32'(errv));
      done("reset");
      foreach (rows[i]) begin
         cfg(32'(rows[i].man));
         rdchk("gain", rgs_pkg::ADDR_CTRL, 12'(rows[i].gain));
         chk("window", 32'(rows[i].win), 32'(digWindow));
         chk("reduction", 32'(rows[i].red), 32'(stage23Reduction));
      end
      done("manual");
      apb(1'b1, rgs_pkg::ADDR_CFG, 32'h0000_0300);
      @(posedge clk_sys);
      chk("clip", 32'h0000_0001, 32'(clipEnable));
      chk("window", 32'h0000_0004, 32'(digWindow));
      chk("reduction", 32'h0000_0002, 32'(stage23Reduction));
      done("force");
      // The host keeps AGC off here so only squelch moves the gain.
      cfg(32'h0000_0002);
      u_rgs_rx_model.frame(1'b1);
      cmd(rgs_pkg::CMD_SQUELCH);
      u_rgs_rx_model.noise(3 * WIN, 1);
      u_rgs_rx_model.strobe(1, 3);
      rdchk("gain", rgs_pkg::ADDR_CTRL, 12'h002);
      u_rgs_rx_model.frame(1'b0);
      cmd(rgs_pkg::CMD_SQUELCH);
      u_rgs_rx_model.noise(10 * WIN + 20, 1);
      rdchk("gain", rgs_pkg::ADDR_CTRL, 12'h00A);
      cmd(rgs_pkg::CMD_RESET_GAIN);
      rdchk("gain", rgs_pkg::ADDR_CTRL, 12'h002);
      cmd(rgs_pkg::CMD_SQUELCH);
      u_rgs_rx_model.noise(4 * WIN, WIN / 2);
      rdchk("gain", rgs_pkg::ADDR_CTRL, 12'h002);
      done("squelch");
      // Noise stops ten cycles into the third window; the mask expiry ends squelch before that window can add a step.
      cfg(32'h0000_0080);
      u_rgs_rx_model.strobe(1, 0);
      u_rgs_rx_model.noise(START + 2 * WIN + 10, 1);
      u_rgs_rx_model.strobe(1, 1);
      u_rgs_rx_model.noise(5 * WIN, 1);
      rdchk("gain", rgs_pkg::ADDR_CTRL, 12'h002);
      done("dynamic");
      cfg(32'h0000_0011);
      u_rgs_rx_model.frame(1'b1);
      rdchk("status", rgs_pkg::ADDR_GAIN, 12'h001);
      rdchk("gain", rgs_pkg::ADDR_CTRL, 12'h004);
      u_rgs_rx_model.level(4'h9, 4'hF);
      u_rgs_rx_model.level(4'h2, 4'h1);
      u_rgs_rx_model.strobe(3, 3);
      rdchk("rssi", rgs_pkg::ADDR_RSSI, 12'h012);
      rdchk("gain", rgs_pkg::ADDR_CTRL, 12'h007);
      u_rgs_rx_model.level(4'h5, 4'hF);
      rdchk("rssi", rgs_pkg::ADDR_RSSI, 12'h0D5);
      u_rgs_rx_model.level(4'h3, 4'h0);
      rdchk("rssi", rgs_pkg::ADDR_RSSI, 12'h0D5);
      u_rgs_rx_model.frame(1'b0);
      u_rgs_rx_model.level(4'hC, 4'hC);
      rdchk("rssi", rgs_pkg::ADDR_RSSI, 12'h0D5);
      rdchk("gain", rgs_pkg::ADDR_CTRL, 12'h001);
      cmd(rgs_pkg::CMD_CLEAR_RSSI);
      rdchk("rssi", rgs_pkg::ADDR_RSSI, 12'h000);
      apb(1'b1, rgs_pkg::ADDR_CFG, 32'h0000_0051);
      u_rgs_rx_model.frame(1'b1);
      rdchk("gain", rgs_pkg::ADDR_CTRL, 12'h000);
      u_rgs_rx_model.frame(1'b0);
      apb(1'b1, rgs_pkg::ADDR_CFG, 32'h0000_0031);
      u_rgs_rx_model.frame(1'b1);
      u_rgs_rx_model.strobe(1, 3);
      u_rgs_rx_model.strobe(8, 2);
      u_rgs_rx_model.strobe(1, 3);
      rdchk("gain", rgs_pkg::ADDR_CTRL, 12'h005);
      u_rgs_rx_model.frame(1'b0);
      done("agc");
      report_and_stop();
   end
endmodule : tb_top
